// File: hdl/cmac_core.v
// memory map, addressing modes, reset state and operating modes of the core
`timescale 1ns/1ps
`include "cmac_regs.vh"
module cmac_core (
    input wire mclk,
    input wire arst_n,
    input wire instrValid,
    input wire [3:0] instrOp,
    input wire [13:0] instrArg,
    input wire regWrEn,
    input wire [2:0] regSel,
    input wire [3:0] regWrData,
    input wire [3:0] ramRdData,
    input wire [6:0] irqSet,
    input wire captureEvt,
    input wire captureErr,
    input wire convDone,
    input wire stopCancel,
    output reg instrReady_r,
    output reg [13:0] romAddr_r,
    output reg romFetch_r,
    output reg [9:0] ramAddr_r,
    output reg ramRdEn_r,
    output reg ramWrEn_r,
    output reg [3:0] ramWrData_r,
    output reg [3:0] regRdData_r,
    output reg status_r,
    output reg statusValid_r,
    output reg [4:0] mode_r,
    output reg [9:0] stackPtr_r,
    output reg ieFlag_r,
    output reg [6:0] irqFlag_r,
    output reg [6:0] irqMask_r,
    output reg [7:0] bitFlags_r
);
    // ****************************************
    // states
    // ****************************************
    localparam [4:0] M_ACT = 5'h01;
    localparam [4:0] M_SUB = 5'h02;
    localparam [4:0] M_SBY = 5'h04;
    localparam [4:0] M_WAT = 5'h08;
    localparam [4:0] M_STP = 5'h10;
    localparam [3:0] P_IDLE = 4'h1;
    localparam [3:0] P_DIR = 4'h2;
    localparam [3:0] P_LOAD = 4'h4;
    localparam [3:0] P_XCHG = 4'h8;

    // ****************************************
    // reset release
    // ****************************************
    reg rstMeta_r;
    reg rstSync_r;
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // stop cancel comes from a pin
    reg cancelMeta_r;
    reg cancelSync_r;
    always @(posedge mclk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            cancelMeta_r <= 1'b0;
            cancelSync_r <= 1'b0;
        end
        else
        begin
            cancelMeta_r <= stopCancel;
            cancelSync_r <= cancelMeta_r;
        end
    end

    // ****************************************
    // decode helpers
    // ****************************************
    // returns {inhibited, executed} for a bit operation
    function [1:0] bitCheck;
        input [3:0] idx;
        input [1:0] cmd;
        input active;
        begin
            case (idx)
                `CMAC_B_IE, `CMAC_B_IM, `CMAC_B_LOW_SPEED_FLAG, `CMAC_B_CONVERTER_CURRENT_OFF_FLAG: bitCheck = 2'h1;
                `CMAC_B_IF, `CMAC_B_CAPTURE_STATUS_FLAG, `CMAC_B_CAPTURE_ERROR_FLAG, `CMAC_B_RAM_ENABLE_FLAG:
                    bitCheck = (cmd == `CMAC_C_SET) ? 2'h0 : 2'h1;
                `CMAC_B_RSP: bitCheck = (cmd == `CMAC_C_SET) ? 2'h0 : ((cmd == `CMAC_C_RST) ? 2'h1 : 2'h2);
                `CMAC_B_WATCHDOG_RUN_FLAG: bitCheck = (cmd == `CMAC_C_SET) ? 2'h1 : ((cmd == `CMAC_C_RST) ? 2'h0 : 2'h2);
                `CMAC_B_CONVERSION_START_BIT: bitCheck = (cmd == `CMAC_C_RST) ? 2'h2 : 2'h1;
                `CMAC_B_DIRECT_TRANSFER_FLAG: bitCheck = (cmd == `CMAC_C_SET && active) ? 2'h0 : 2'h1;
                default: bitCheck = (cmd == `CMAC_C_TEST) ? 2'h2 : 2'h0;
            endcase
        end
    endfunction

    function [2:0] opKind;
        input [3:0] op;
        begin
            case (op)
                `CMAC_OP_BR: opKind = `CMAC_K_PAGE;
                `CMAC_OP_CAL: opKind = `CMAC_K_ZERO;
                `CMAC_OP_TBR: opKind = `CMAC_K_TABLE;
                `CMAC_OP_PFETCH: opKind = `CMAC_K_PAT;
                default: opKind = `CMAC_K_LONG;
            endcase
        end
    endfunction

    // lowest pending request wins
    function [2:0] firstPend;
        input [6:0] p;
        integer i;
        begin
            firstPend = 3'h0;
            for (i = 6; i >= 0; i = i - 1)
                if (p[i])
                    firstPend = i[2:0];
        end
    endfunction

    // ****************************************
    // architectural registers
    // ****************************************
    reg [3:0] acc_r;
    reg [3:0] breg_r;
    reg [1:0] bank_r;
    reg [3:0] mid_r;
    reg [3:0] low_r;
    reg [3:0] auxFirst_r;
    reg [3:0] auxSecond_r;
    reg carry_r;
    reg [13:0] pc_r;
    reg rsp_r;
    reg dirWr_r;
    reg [3:0] phase_r;
    reg [4:0] modeNxt;
    reg [3:0] phaseNxt;

    wire [6:0] pendMask = irqFlag_r & ~irqMask_r;
    wire anyPend = |pendMask;
    wire running = (mode_r == M_ACT) || (mode_r == M_SUB);
    wire accept = instrValid & instrReady_r;
    wire acceptOp = accept & (phase_r == P_IDLE);
    wire acceptDir = accept & (phase_r == P_DIR);
    wire takeIrq = running & (phase_r == P_IDLE) & ~accept & ieFlag_r & anyPend;
    wire lpNop = ~ieFlag_r & anyPend;
    wire [2:0] pendIdx = firstPend(pendMask);
    wire [2:0] pendIdxP1 = pendIdx + 3'h1;
    wire [13:0] vecArg = {10'h000, pendIdxP1, 1'b0};
    wire isBranch = (instrOp == `CMAC_OP_LBR) || (instrOp == `CMAC_OP_BR) || (instrOp == `CMAC_OP_TBR);
    wire isJump = (instrOp == `CMAC_OP_LJMP) || (instrOp == `CMAC_OP_LCALL) || (instrOp == `CMAC_OP_CAL);
    wire [1:0] bitChk = bitCheck(instrArg[3:0], instrArg[5:4], mode_r == M_ACT);
    wire bitDo = acceptOp & (instrOp == `CMAC_OP_BITOP) & bitChk[0];
    wire bitSetDo = bitDo & (instrArg[5:4] == `CMAC_C_SET);
    wire bitRstDo = bitDo & (instrArg[5:4] == `CMAC_C_RST);
    // a bit test only reads, so it must never write the flag back
    wire bitWrDo = bitSetDo | bitRstDo;
    wire [2:0] lane = instrArg[`CMAC_A_LANE_HI:`CMAC_A_LANE_LO];
    wire [13:0] romTarget;
    wire [9:0] ramAddrW;
    wire [2:0] romKind = takeIrq ? `CMAC_K_VEC : opKind(instrOp);
    wire [13:0] romArg = takeIrq ? vecArg : instrArg;
    wire [1:0] ramKind = (phase_r == P_DIR) ? `CMAC_RK_DIR :
        (((instrOp == `CMAC_OP_LOAD_MEMREG_INSTR) || (instrOp == `CMAC_OP_EXCHANGE_MEMREG_INSTR)) ? `CMAC_RK_MR : `CMAC_RK_IND);
    wire [13:0] pcInc = pc_r + 14'h0001;
    wire [9:0] spDec = stackPtr_r - 10'h001;

    cmac_rom_target romTgt (
        .kind(romKind),
        .pc(pc_r),
        .arg(romArg),
        .acc(acc_r),
        .breg(breg_r),
        .target(romTarget)
    );

    cmac_ram_addr ramAdr (
        .kind(ramKind),
        .bank(bank_r),
        .mid(mid_r),
        .low(low_r),
        .arg(instrArg[9:0]),
        .addr(ramAddrW)
    );

    // ****************************************
    // mode and phase sequencing
    // ****************************************
    always @*
    begin
        modeNxt = mode_r;
        phaseNxt = phase_r;
        case (mode_r)
            M_ACT, M_SUB:
            begin
                // cancelled low-power entry falls through as a nop
                if (acceptOp && instrOp == `CMAC_OP_STOP && !lpNop)
                    modeNxt = (mode_r == M_SUB && bitFlags_r[`CMAC_F_DIRECT_TRANSFER_FLAG]) ? M_ACT :
                        (bitFlags_r[`CMAC_F_LOW_SPEED_FLAG] ? M_WAT : M_STP);
                else if (acceptOp && instrOp == `CMAC_OP_SBY && !lpNop)
                    modeNxt = M_SBY;
            end
            M_SBY, M_WAT:
            begin
                if (anyPend)
                    modeNxt = bitFlags_r[`CMAC_F_LOW_SPEED_FLAG] ? M_SUB : M_ACT;
            end
            M_STP:
            begin
                if (cancelSync_r)
                    modeNxt = M_ACT;
            end
            default: modeNxt = M_ACT;
        endcase
        case (phase_r)
            P_IDLE:
            begin
                if (acceptOp)
                    case (instrOp)
                        `CMAC_OP_RAMDIR: phaseNxt = P_DIR;
                        `CMAC_OP_RAMIND: phaseNxt = instrArg[`CMAC_A_WR] ? P_IDLE : P_LOAD;
                        `CMAC_OP_LOAD_MEMREG_INSTR: phaseNxt = P_LOAD;
                        `CMAC_OP_EXCHANGE_MEMREG_INSTR: phaseNxt = P_XCHG;
                        default: phaseNxt = P_IDLE;
                    endcase
            end
            P_DIR:
            begin
                if (acceptDir)
                    phaseNxt = dirWr_r ? P_IDLE : P_LOAD;
            end
            P_LOAD, P_XCHG: phaseNxt = P_IDLE;
            default: phaseNxt = P_IDLE;
        endcase
    end

    // ****************************************
    // datapath and program flow
    // ****************************************
    always @(posedge mclk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            mode_r <= M_ACT;
            phase_r <= P_IDLE;
            instrReady_r <= 1'b0;
            pc_r <= `CMAC_PC_RST;
            stackPtr_r <= `CMAC_SP_RST;
            romAddr_r <= `CMAC_PC_RST;
            romFetch_r <= 1'b0;
            ramAddr_r <= 10'h000;
            ramRdEn_r <= 1'b0;
            ramWrEn_r <= 1'b0;
            ramWrData_r <= `CMAC_REG_RST;
            regRdData_r <= `CMAC_REG_RST;
            status_r <= `CMAC_ST_RST;
            statusValid_r <= 1'b1;
            acc_r <= `CMAC_REG_RST;
            breg_r <= `CMAC_REG_RST;
            bank_r <= 2'h0;
            mid_r <= `CMAC_REG_RST;
            low_r <= `CMAC_REG_RST;
            auxFirst_r <= `CMAC_REG_RST;
            auxSecond_r <= `CMAC_REG_RST;
            carry_r <= 1'b0;
            dirWr_r <= 1'b0;
        end
        else
        begin
            mode_r <= modeNxt;
            phase_r <= phaseNxt;
            instrReady_r <= ((modeNxt == M_ACT) || (modeNxt == M_SUB)) &&
                ((phaseNxt == P_IDLE) || (phaseNxt == P_DIR));
            romFetch_r <= 1'b0;
            ramRdEn_r <= 1'b0;
            ramWrEn_r <= 1'b0;
            case (regSel)
                3'h0: regRdData_r <= acc_r;
                3'h1: regRdData_r <= breg_r;
                3'h2: regRdData_r <= {2'h0, bank_r};
                3'h3: regRdData_r <= mid_r;
                3'h4: regRdData_r <= low_r;
                3'h5: regRdData_r <= auxFirst_r;
                3'h6: regRdData_r <= auxSecond_r;
                default: regRdData_r <= {3'h0, carry_r};
            endcase
            if (regWrEn && running)
                case (regSel)
                    3'h0: acc_r <= regWrData;
                    3'h1: breg_r <= regWrData;
                    3'h2: bank_r <= regWrData[1:0];
                    3'h3: mid_r <= regWrData;
                    3'h4: low_r <= regWrData;
                    3'h5: auxFirst_r <= regWrData;
                    3'h6: auxSecond_r <= regWrData;
                    default: carry_r <= regWrData[0];
                endcase
            if (phase_r == P_LOAD)
                acc_r <= ramRdData;
            if (phase_r == P_XCHG)
            begin
                acc_r <= ramRdData;
                ramWrEn_r <= 1'b1;
                ramWrData_r <= acc_r;
            end
            if (acceptOp)
            begin
                romFetch_r <= 1'b1;
                pc_r <= pcInc;
                romAddr_r <= pcInc;
                if (isJump || (isBranch && status_r))
                begin
                    pc_r <= romTarget;
                    romAddr_r <= romTarget;
                end
                if (instrOp == `CMAC_OP_PFETCH)
                    romAddr_r <= romTarget;
                if (instrOp == `CMAC_OP_LCALL || instrOp == `CMAC_OP_CAL)
                    stackPtr_r <= spDec;
                if (isBranch)
                begin
                    status_r <= 1'b1;
                    statusValid_r <= 1'b1;
                end
                if (instrOp == `CMAC_OP_RAMIND || instrOp == `CMAC_OP_LOAD_MEMREG_INSTR || instrOp == `CMAC_OP_EXCHANGE_MEMREG_INSTR)
                begin
                    ramAddr_r <= ramAddrW;
                    ramRdEn_r <= !(instrOp == `CMAC_OP_RAMIND && instrArg[`CMAC_A_WR]);
                    ramWrEn_r <= instrOp == `CMAC_OP_RAMIND && instrArg[`CMAC_A_WR];
                    ramWrData_r <= acc_r;
                end
                if (instrOp == `CMAC_OP_RAMDIR)
                    dirWr_r <= instrArg[`CMAC_A_WR];
                if (instrOp == `CMAC_OP_BITOP)
                begin
                    // a bit that is barred for this operation leaves no trustworthy status
                    statusValid_r <= ~bitChk[1];
                    if (instrArg[5:4] == `CMAC_C_TEST && bitChk[0])
                        case (instrArg[3:0])
                            `CMAC_B_IE: status_r <= ieFlag_r;
                            `CMAC_B_IM: status_r <= irqMask_r[lane];
                            `CMAC_B_IF: status_r <= irqFlag_r[lane];
                            `CMAC_B_LOW_SPEED_FLAG: status_r <= bitFlags_r[`CMAC_F_LOW_SPEED_FLAG];
                            `CMAC_B_CONVERTER_CURRENT_OFF_FLAG: status_r <= bitFlags_r[`CMAC_F_CONVERTER_CURRENT_OFF_FLAG];
                            `CMAC_B_CAPTURE_STATUS_FLAG: status_r <= bitFlags_r[`CMAC_F_CAPTURE_STATUS_FLAG];
                            `CMAC_B_CAPTURE_ERROR_FLAG: status_r <= bitFlags_r[`CMAC_F_CAPTURE_ERROR_FLAG];
                            `CMAC_B_RAM_ENABLE_FLAG: status_r <= bitFlags_r[`CMAC_F_RAM_ENABLE_FLAG];
                            `CMAC_B_RSP: status_r <= rsp_r;
                            `CMAC_B_CONVERSION_START_BIT: status_r <= bitFlags_r[`CMAC_F_CONVERSION_START_BIT];
                            `CMAC_B_DIRECT_TRANSFER_FLAG: status_r <= bitFlags_r[`CMAC_F_DIRECT_TRANSFER_FLAG];
                            default: status_r <= status_r;
                        endcase
                end
            end
            if (acceptDir)
            begin
                ramAddr_r <= ramAddrW;
                ramRdEn_r <= ~dirWr_r;
                ramWrEn_r <= dirWr_r;
                ramWrData_r <= acc_r;
                pc_r <= pcInc;
                romAddr_r <= pcInc;
                romFetch_r <= 1'b1;
            end
            if (takeIrq)
            begin
                pc_r <= romTarget;
                romAddr_r <= romTarget;
                romFetch_r <= 1'b1;
                stackPtr_r <= spDec;
            end
            // leaving stop reloads only pc and rom address, so the cpu restarts from the reset vector
            if (mode_r == M_STP && modeNxt == M_ACT)
            begin
                pc_r <= `CMAC_PC_RST;
                romAddr_r <= `CMAC_PC_RST;
                romFetch_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // interrupt control and bit-register flags
    // ****************************************
    wire ifClr = bitRstDo && instrArg[3:0] == `CMAC_B_IF;
    wire [6:0] ifClrMask = ifClr ? (7'h01 << lane) : 7'h00;
    wire [6:0] laneMask = 7'h01 << lane;
    always @(posedge mclk or negedge rstSync_r)
    begin
        if (!rstSync_r)
        begin
            ieFlag_r <= 1'b0;
            irqFlag_r <= `CMAC_IF_RST;
            irqMask_r <= `CMAC_IM_RST;
            bitFlags_r <= `CMAC_BF_RST;
            rsp_r <= 1'b0;
        end
        else
        begin
            // hardware set beats a software clear in the same cycle
            irqFlag_r <= (irqFlag_r & ~ifClrMask) | irqSet;
            if (takeIrq)
                ieFlag_r <= 1'b0;
            else if (bitWrDo && instrArg[3:0] == `CMAC_B_IE)
                ieFlag_r <= bitSetDo;
            if (bitWrDo && instrArg[3:0] == `CMAC_B_IM)
                irqMask_r <= bitSetDo ? (irqMask_r | laneMask) : (irqMask_r & ~laneMask);
            if (bitRstDo && instrArg[3:0] == `CMAC_B_RSP)
                rsp_r <= 1'b0;
            if (bitWrDo)
                case (instrArg[3:0])
                    `CMAC_B_WATCHDOG_RUN_FLAG: bitFlags_r[`CMAC_F_WATCHDOG_RUN_FLAG] <= 1'b1;
                    `CMAC_B_CONVERSION_START_BIT: bitFlags_r[`CMAC_F_CONVERSION_START_BIT] <= 1'b1;
                    `CMAC_B_CAPTURE_STATUS_FLAG: bitFlags_r[`CMAC_F_CAPTURE_STATUS_FLAG] <= captureEvt;
                    `CMAC_B_CAPTURE_ERROR_FLAG: bitFlags_r[`CMAC_F_CAPTURE_ERROR_FLAG] <= captureErr;
                    `CMAC_B_CONVERTER_CURRENT_OFF_FLAG: bitFlags_r[`CMAC_F_CONVERTER_CURRENT_OFF_FLAG] <= bitSetDo;
                    `CMAC_B_RAM_ENABLE_FLAG: bitFlags_r[`CMAC_F_RAM_ENABLE_FLAG] <= 1'b0;
                    `CMAC_B_LOW_SPEED_FLAG: bitFlags_r[`CMAC_F_LOW_SPEED_FLAG] <= bitSetDo;
                    `CMAC_B_DIRECT_TRANSFER_FLAG: bitFlags_r[`CMAC_F_DIRECT_TRANSFER_FLAG] <= bitSetDo;
                    default: bitFlags_r <= bitFlags_r;
                endcase
            if (captureEvt)
                bitFlags_r[`CMAC_F_CAPTURE_STATUS_FLAG] <= 1'b1;
            if (captureErr)
                bitFlags_r[`CMAC_F_CAPTURE_ERROR_FLAG] <= 1'b1;
            if (convDone)
                bitFlags_r[`CMAC_F_CONVERSION_START_BIT] <= 1'b0;
            if (mode_r == M_WAT && modeNxt != M_WAT)
                bitFlags_r[`CMAC_F_RAM_ENABLE_FLAG] <= 1'b1;
        end
    end
endmodule // cmac_core

// File: hdl/cmac_regs.vh
// constants for the cpu memory addressing core
`ifndef CMAC_REGS_VH
`define CMAC_REGS_VH
// ****************************************
// rom map
// ****************************************
`define CMAC_VEC_TOP 14'h000F
`define CMAC_ZPAGE_TOP 14'h003F
`define CMAC_PAT_TOP 14'h0FFF
`define CMAC_ROM_TOP 14'h3FFF
// ****************************************
// ram map
// ****************************************
`define CMAC_MR_BASE 10'h040
// ****************************************
// reset values
// ****************************************
`define CMAC_PC_RST 14'h0000
`define CMAC_SP_RST 10'h3FF
`define CMAC_ST_RST 1'b1
`define CMAC_IM_RST 7'h7F
`define CMAC_IF_RST 7'h00
`define CMAC_BF_RST 8'h00
`define CMAC_REG_RST 4'h0
// ****************************************
// operation codes
// ****************************************
`define CMAC_OP_NOP 4'h0
`define CMAC_OP_LJMP 4'h1
`define CMAC_OP_LBR 4'h2
`define CMAC_OP_LCALL 4'h3
`define CMAC_OP_BR 4'h4
`define CMAC_OP_CAL 4'h5
`define CMAC_OP_TBR 4'h6
`define CMAC_OP_PFETCH 4'h7
`define CMAC_OP_RAMIND 4'h8
`define CMAC_OP_RAMDIR 4'h9
`define CMAC_OP_LOAD_MEMREG_INSTR 4'hA
`define CMAC_OP_EXCHANGE_MEMREG_INSTR 4'hB
`define CMAC_OP_BITOP 4'hC
`define CMAC_OP_STOP 4'hD
`define CMAC_OP_SBY 4'hE
// ****************************************
// target kinds
// ****************************************
`define CMAC_K_LONG 3'h0
`define CMAC_K_PAGE 3'h1
`define CMAC_K_ZERO 3'h2
`define CMAC_K_TABLE 3'h3
`define CMAC_K_PAT 3'h4
`define CMAC_K_VEC 3'h5
`define CMAC_RK_IND 2'h0
`define CMAC_RK_DIR 2'h1
`define CMAC_RK_MR 2'h2
// ****************************************
// bit operation targets and commands
// ****************************************
`define CMAC_B_IE 4'h0
`define CMAC_B_LOW_SPEED_FLAG 4'h1
`define CMAC_B_CONVERTER_CURRENT_OFF_FLAG 4'h2
`define CMAC_B_CAPTURE_STATUS_FLAG 4'h3
`define CMAC_B_CAPTURE_ERROR_FLAG 4'h4
`define CMAC_B_RAM_ENABLE_FLAG 4'h5
`define CMAC_B_RSP 4'h6
`define CMAC_B_WATCHDOG_RUN_FLAG 4'h7
`define CMAC_B_CONVERSION_START_BIT 4'h8
`define CMAC_B_DIRECT_TRANSFER_FLAG 4'h9
`define CMAC_B_IF 4'hA
`define CMAC_B_IM 4'hB
`define CMAC_C_SET 2'h0
`define CMAC_C_RST 2'h1
`define CMAC_C_TEST 2'h2
// positions in the bit flag vector
`define CMAC_F_WATCHDOG_RUN_FLAG 0
`define CMAC_F_CONVERSION_START_BIT 1
`define CMAC_F_CAPTURE_STATUS_FLAG 2
`define CMAC_F_CAPTURE_ERROR_FLAG 3
`define CMAC_F_CONVERTER_CURRENT_OFF_FLAG 4
`define CMAC_F_RAM_ENABLE_FLAG 5
`define CMAC_F_LOW_SPEED_FLAG 6
`define CMAC_F_DIRECT_TRANSFER_FLAG 7
// argument field positions
`define CMAC_A_WR 13
`define CMAC_A_LANE_HI 8
`define CMAC_A_LANE_LO 6
`endif

// File: hdl/cmac_rom_target.v
// rom branch and fetch target former
`timescale 1ns/1ps
`include "cmac_regs.vh"
module cmac_rom_target (
    input wire [2:0] kind,
    input wire [13:0] pc,
    input wire [13:0] arg,
    input wire [3:0] acc,
    input wire [3:0] breg,
    output reg [13:0] target
);
    always @*
    begin
        case (kind)
            `CMAC_K_LONG: target = arg & `CMAC_ROM_TOP;
            `CMAC_K_PAGE: target = {pc[13:8], arg[7:0]};
            `CMAC_K_ZERO: target = arg & `CMAC_ZPAGE_TOP;
            `CMAC_K_TABLE: target = {arg[3:0], breg, acc, 2'h0};
            `CMAC_K_PAT: target = arg & `CMAC_PAT_TOP;
            `CMAC_K_VEC: target = arg & `CMAC_VEC_TOP;
            default: target = pc;
        endcase
    end
endmodule // cmac_rom_target

// File: hdl/cmac_ram_addr.v
// ram address former for the three ram addressing modes
`timescale 1ns/1ps
`include "cmac_regs.vh"
module cmac_ram_addr (
    input wire [1:0] kind,
    input wire [1:0] bank,
    input wire [3:0] mid,
    input wire [3:0] low,
    input wire [9:0] arg,
    output reg [9:0] addr
);
    always @*
    begin
        case (kind)
            `CMAC_RK_IND: addr = {bank, mid, low};
            `CMAC_RK_DIR: addr = arg;
            `CMAC_RK_MR: addr = `CMAC_MR_BASE | {6'h00, arg[3:0]};
            default: addr = {bank, mid, low};
        endcase
    end
endmodule // cmac_ram_addr

// File: testbench/cmac_core_monitor.sv
// port checks on the addressing core
`timescale 1ns/1ps
module cmac_core_monitor (
    input logic mclk,
    input logic arst_n,
    input logic instrValid,
    input logic [3:0] instrOp,
    input logic [13:0] instrArg,
    input logic instrReady_r,
    input logic [13:0] romAddr_r,
    input logic romFetch_r,
    input logic [9:0] ramAddr_r,
    input logic ramRdEn_r,
    input logic ramWrEn_r,
    input logic status_r,
    input logic statusValid_r,
    input logic [4:0] mode_r,
    input logic [9:0] stackPtr_r
);
// *****
// take tracker
// *****
logic takeQ, dirQ, stQ;
logic [3:0] opQ;
logic [13:0] argQ;
logic [9:0] spQ;
// address word after a direct access carries no op
wire take = instrValid & instrReady_r & ~dirQ;
always @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
        takeQ <= 1'b0;
        dirQ <= 1'b0;
    end
    else
    begin
        takeQ <= take;
        if (instrValid && instrReady_r)
            dirQ <= take && instrOp == 4'h9;
    end
always @(posedge mclk)
    if (take)
    begin
        opQ <= instrOp;
        argQ <= instrArg;
        stQ <= status_r;
        spQ <= stackPtr_r;
    end
default clocking cb @(posedge mclk); endclocking
default disable iff (!arst_n);
a_long_jump: assert property (takeQ && opQ == 4'h1 |-> romAddr_r == argQ) else $error("long jump");
a_zero_call: assert property (takeQ && opQ == 4'h5 |-> romAddr_r == {8'h00, argQ[5:0]}) else $error("cal");
a_call_stack: assert property (takeQ && (opQ == 4'h3 || opQ == 4'h5) |-> stackPtr_r == spQ - 10'h001)
    else $error("sp");
a_fetch_pulse: assert property (takeQ |-> romFetch_r) else $error("fetch");
a_page_branch: assert property (takeQ && opQ == 4'h4 && stQ |-> romAddr_r[7:0] == argQ[7:0]) else $error("br");
a_pat_fetch: assert property (takeQ && opQ == 4'h7 |-> romAddr_r == {2'b00, argQ[11:0]}) else $error("pat");
a_memreg_read: assert property (takeQ && opQ == 4'hA |-> ramRdEn_r && ramAddr_r == {6'h04, argQ[3:0]}) else $error("mr");
a_memreg_swap: assert property (takeQ && opQ == 4'hB |-> ##1 ramWrEn_r && ramAddr_r[9:4] == 6'h04) else $error("xm");
a_bad_bit: assert property (takeQ && opQ == 4'hC && (argQ[5:0] == 6'h26 || argQ[5:0] == 6'h18) |-> !statusValid_r)
    else $error("bit");
a_mode_onehot: assert property ($onehot(mode_r)) else $error("mode");
cover property (takeQ && opQ == 4'hB);
cover property (takeQ && opQ == 4'h6);
cover property (!statusValid_r);
endmodule // cmac_core_monitor
bind cmac_core cmac_core_monitor u_mon (.*);

// File: testbench/cmac_core_tb_top.sv
// directed bench for the addressing core
`timescale 1ns/1ps
module cmac_core_tb_top;
logic mclk, arst_n, instrValid, regWrEn, captureEvt, captureErr, convDone, stopCancel;
logic instrReady_r, romFetch_r, ramRdEn_r, ramWrEn_r, status_r, statusValid_r, ieFlag_r;
logic [3:0] instrOp, regWrData, ramRdData, ramWrData_r, regRdData_r;
logic [13:0] instrArg, romAddr_r;
logic [2:0] regSel;
logic [6:0] irqSet, irqFlag_r, irqMask_r;
logic [9:0] ramAddr_r, stackPtr_r;
logic [4:0] mode_r;
logic [7:0] bitFlags_r;
logic [13:0] bops [3] = '{14'h0026, 14'h0027, 14'h0018};
int err_total, n_compared;
cmac_core DUT (.*);
initial
begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
end
// *****
// tasks
// *****
task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
        err_total++;
        $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
endtask
// ready is looked at mid-cycle so the take edge is never raced
task issue(input logic [3:0] op, input logic [13:0] arg);
    @(posedge mclk);
    instrValid <= 1'b1;
    instrOp <= op;
    instrArg <= arg;
    do @(negedge mclk); while (instrReady_r !== 1'b1);
    @(posedge mclk);
    instrValid <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
endtask
task wreg(input logic [2:0] s, input logic [3:0] d);
    @(posedge mclk);
    regWrEn <= 1'b1;
    regSel <= s;
    regWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
endtask
task rreg(input logic [2:0] s, input logic [3:0] e);
    @(posedge mclk);
    regSel <= s;
    @(posedge mclk);
    @(negedge mclk);
    chk(regRdData_r, e);
endtask
task tdone(input string s);
    $display("test %0s done, mismatches so far %0d", s, err_total);
endtask
task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask
initial
begin
    repeat (3000) @(posedge mclk);
    err_total++;
    $display("mismatch at %0t: timeout", $time);
    stop_test;
end
// *****
// tests
// *****
initial
begin
    {arst_n, instrValid, regWrEn, captureEvt, captureErr, convDone, stopCancel} = 7'h00;
    {instrOp, instrArg, regSel, regWrData, irqSet} = 32'h0;
    ramRdData = 4'h9;
    repeat (20) @(posedge mclk);
    chk(stackPtr_r, 10'h3FF);
    chk(romAddr_r, 14'h0000);
    chk({ieFlag_r, irqFlag_r, irqMask_r}, 15'h007F);
    chk(bitFlags_r, 8'h00);
    chk(mode_r, 5'h01);
    arst_n <= 1'b1;
    tdone("reset");
    issue(4'h1, 14'h3FFF);
    chk(romAddr_r, 14'h3FFF);
    issue(4'h5, 14'h3FFF);
    chk(romAddr_r, 14'h003F);
    chk(stackPtr_r, 10'h3FE);
    issue(4'h4, 14'h3FA5);
    chk(romAddr_r, 14'h00A5);
    wreg(3'h0, 4'h5);
    wreg(3'h1, 4'hA);
    issue(4'h6, 14'h0003);
    chk(romAddr_r, 14'h0E94);
    issue(4'h7, 14'h3ABC);
    chk(romAddr_r, 14'h0ABC);
    tdone("rom");
    wreg(3'h2, 4'h2);
    wreg(3'h3, 4'h5);
    wreg(3'h4, 4'hC);
    issue(4'h8, 14'h0000);
    chk(ramAddr_r, 10'h25C);
    issue(4'h9, 14'h2000);
    issue(4'hF, 14'h0123);
    chk(ramAddr_r, 10'h123);
    // new read data so the load is seen, not left over
    @(posedge mclk);
    ramRdData <= 4'h3;
    issue(4'hA, 14'h0007);
    chk(ramAddr_r, 10'h047);
    rreg(3'h0, 4'h3);
    wreg(3'h0, 4'h6);
    issue(4'hB, 14'h000F);
    chk(ramAddr_r, 10'h04F);
    chk({ramWrEn_r, ramWrData_r}, 5'h16);
    rreg(3'h0, 4'h3);
    tdone("ram");
    foreach (bops[i])
    begin
        issue(4'hC, 14'h0020);
        chk(statusValid_r, 1'b1);
        issue(4'hC, bops[i]);
        chk(statusValid_r, 1'b0);
    end
    // unmask one source, then raise it with interrupts off
    issue(4'hC, 14'h001B);
    @(posedge mclk);
    irqSet <= 7'h01;
    @(posedge mclk);
    irqSet <= 7'h00;
    issue(4'hD, 14'h0000);
    chk(mode_r, 5'h01);
    issue(4'hE, 14'h0000);
    chk(mode_r, 5'h01);
    // clear the request so standby is really entered, then wake it
    issue(4'hC, 14'h001A);
    issue(4'hE, 14'h0000);
    chk(mode_r, 5'h04);
    @(posedge mclk);
    irqSet <= 7'h01;
    @(posedge mclk);
    irqSet <= 7'h00;
    @(posedge mclk);
    @(negedge mclk);
    chk(mode_r, 5'h01);
    tdone("modes");
    stop_test;
end
endmodule // cmac_core_tb_top
